// file: include/tws_params.svh
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// =====================================================================
// Address word layout and protocol counts
`define TWS_CTRL_CODE 4'ha
`define TWS_BIT_ACK 4'h8
`define TWS_BIT_END 4'h9
`define TWS_PAGE_BYTES 8
`define TWS_PAGE_BITS 3

// =====================================================================
// Timing: clock rate and internal nonvolatile write time
`define TWS_CLK_MHZ 50
`define TWS_NV_WRITE_CYCLE_TIME_US 10000
`define TWS_NV_WRITE_CYCLES (`TWS_NV_WRITE_CYCLE_TIME_US * `TWS_CLK_MHZ)
`define TWS_NV_CNT_BITS 24

`endif

// file: include/tws_pkg.sv
package tws_pkg;

  // =====================================================================
  // Protocol states of the serial slave
  typedef enum logic [2:0]
  {
    TWS_IDLE = 3'b000,
    TWS_DEV = 3'b001,
    TWS_MADDR = 3'b010,
    TWS_WDATA = 3'b011,
    TWS_READ = 3'b100
  } tws_state_type;

  // Next address inside the aligned eight-byte page
  function automatic logic [7:0] tws_page_next(input logic [7:0] addr);
    tws_page_next = {addr[7:3], addr[2:0] + 3'h1};
  endfunction : tws_page_next

endpackage : tws_pkg

// file: src/tws_line_detect.sv
`timescale 1ns/1ps

// =====================================================================
// Clock edges and start / stop conditions on the two bus lines
module tws_line_detect
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);

  logic scl_r;
  logic sda_r;

  // Previous line levels; idle bus is high on both lines
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end
    else if (ce_in)
    begin
      scl_r <= scl_in;
      sda_r <= sda_in;
    end
  end

  // Data moving while the clock is high is a control condition [RULE1]
  assign scl_rise_out = ce_in & scl_in & ~scl_r;
  assign scl_fall_out = ce_in & ~scl_in & scl_r;
  assign start_out = ce_in & scl_in & scl_r & sda_r & ~sda_in; // [RULE2]
  assign stop_out = ce_in & scl_in & scl_r & ~sda_r & sda_in; // [RULE3]

endmodule : tws_line_detect

// file: src/tws_nv_store.sv
`timescale 1ns/1ps
`include "tws_params.svh"

// =====================================================================
// Memory array, page buffer and timed nonvolatile commit
module tws_nv_store
  import tws_pkg::*;
#(
  parameter logic [`TWS_NV_CNT_BITS-1:0] NV_CYCLES = `TWS_NV_CNT_BITS'(`TWS_NV_WRITE_CYCLES)
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic buf_wr_in,
  input wire logic [7:0] buf_addr_in,
  input wire logic [7:0] buf_data_in,
  input wire logic commit_in,
  input wire logic discard_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  output logic busy_out
);

  logic [7:0] mem [0:255];
  logic [7:0] page_buf [0:`TWS_PAGE_BYTES-1];
  logic [`TWS_PAGE_BYTES-1:0] valid_r;
  logic [4:0] base_r;
  logic busy_r;
  logic [`TWS_NV_CNT_BITS-1:0] cnt_r;

  wire logic [`TWS_PAGE_BITS-1:0] slot = cnt_r[`TWS_PAGE_BITS-1:0];
  wire logic copy_now = busy_r && (cnt_r < `TWS_NV_CNT_BITS'(`TWS_PAGE_BYTES)) && valid_r[slot];
  wire logic done = busy_r && (cnt_r == NV_CYCLES - `TWS_NV_CNT_BITS'(1));

  // Page buffer; only bytes of the last addressed page are kept
  always_ff @(posedge clk_in)
  begin
    if (ce_in && buf_wr_in)
      page_buf[buf_addr_in[2:0]] <= buf_data_in;
  end

  // Valid mask and commit timer; a discard drops all pending bytes [RULE13]
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      valid_r <= '0;
      base_r <= 5'h00;
      busy_r <= 1'b0;
      cnt_r <= '0;
    end
    else if (ce_in)
    begin
      if (discard_in || done)
        valid_r <= '0;
      else if (buf_wr_in)
        valid_r[buf_addr_in[2:0]] <= 1'b1;
      if (buf_wr_in)
        base_r <= buf_addr_in[7:3];
      if (commit_in && |valid_r)
        busy_r <= 1'b1; // [RULE11]
      else if (done)
        busy_r <= 1'b0;
      cnt_r <= busy_r ? cnt_r + `TWS_NV_CNT_BITS'(1) : '0;
    end
  end

  // Array write one byte per cycle in the first eight cycles of the timed cycle; read is registered
  always_ff @(posedge clk_in)
  begin
    if (ce_in && copy_now)
      mem[{base_r, slot}] <= page_buf[slot];
    if (ce_in)
      rd_data_out <= mem[rd_addr_in];
  end

  assign busy_out = busy_r;

endmodule : tws_nv_store

// file: src/tws_slave.sv
`timescale 1ns/1ps
`include "tws_params.svh"

// =====================================================================
// Two-wire memory slave: serial front end for the device memory map
// Contract
// [RULE1] Data is sampled on clock rise; changes while clock high are control.
// [RULE2] Data falling with clock high is a start and begins a transfer.
// [RULE3] Data rising with clock high is a stop; the slave goes to standby.
// [RULE4] Slave pulls data low through the ninth clock after each accepted byte.
// [RULE5] Standby after reset, after a stop and when internal work ends.
// [RULE6] Master recovers the bus by clocking and issuing a fresh start.
// [RULE7] Address word arrives MSB first: control code, select bits, direction.
// [RULE8] Direction bit one starts a read, zero starts a write.
// [RULE9] Acknowledge only on select match; otherwise drop to standby silently.
// [RULE10] In a write, memory address and data bytes are each acknowledged.
// [RULE11] After a write stop, timed commit runs and bus input is ignored.
// [RULE12] Page writes take up to eight bytes before the stop.
// [RULE13] A write not closed by a stop is discarded, never committed.
// [RULE14] During the commit, address polls are not acknowledged.
// [RULE15] Pointer holds last address plus one and wraps to zero. After a page write the code wraps it inside the eight-byte page instead.
// [RULE16] Current read shifts out the byte at the pointer after the ack.
// [RULE17] Random read is a dummy write of the address then a repeated start.
// [RULE18] Each master ack sends the next byte, address wrapping to zero.
// [RULE19] Master ends a read with no ack then a stop.
// [RULE20] Write-protect high rejects all written data bytes.
// [RULE21] Temperature conversion is held off while a transfer is active.
// [RULE22] Page write addresses wrap inside the aligned eight-byte page.
module tws_slave
  import tws_pkg::*;
#(
  parameter logic [`TWS_NV_CNT_BITS-1:0] NV_CYCLES = `TWS_NV_CNT_BITS'(`TWS_NV_WRITE_CYCLES)
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic select_pin_high_in,
  input wire logic select_pin_mid_in,
  input wire logic select_pin_low_in,
  input wire logic wp_in,
  output logic standby_out,
  output logic conv_hold_out,
  output logic nv_busy_out
);

  // =====================================================================
  // Declarations
  tws_state_type state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic sda_low_r;
  logic rw_r;
  logic mack_r;
  logic [7:0] ptr_r;
  logic [7:0] waddr_r;
  logic wr_pend_r;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic [7:0] rd_data;
  logic busy;

  // =====================================================================
  // Line conditions and memory
  tws_line_detect u_detect
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(start),
    .stop_out(stop)
  );

  // Data byte goes to the page buffer only when write protect is low
  wire logic buf_wr = scl_fall && (cnt_r == `TWS_BIT_ACK) && (state_r == TWS_WDATA) && !wp_in; // [RULE20]

  tws_nv_store #(.NV_CYCLES(NV_CYCLES)) u_store
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .buf_wr_in(buf_wr),
    .buf_addr_in(waddr_r),
    .buf_data_in(shift_r),
    .commit_in(stop && wr_pend_r), // [RULE11]
    .discard_in(start && wr_pend_r), // [RULE13]
    .rd_addr_in(ptr_r),
    .rd_data_out(rd_data),
    .busy_out(busy)
  );

  // =====================================================================
  // Decode of byte boundaries and acknowledge decisions
  wire logic receiving = (state_r == TWS_DEV) || (state_r == TWS_MADDR) || (state_r == TWS_WDATA);
  wire logic byte_done = scl_fall && (cnt_r == `TWS_BIT_ACK);
  wire logic ack_end = scl_fall && (cnt_r == `TWS_BIT_END);
  wire logic [2:0] pins = {select_pin_high_in, select_pin_mid_in, select_pin_low_in};
  // Control code, select bits and direction in MSB-first order [RULE7]
  wire logic dev_match = (shift_r[7:4] == `TWS_CTRL_CODE) && (shift_r[3:1] == pins);
  // A busy store refuses every address word, so polls see no ack [RULE14]
  wire logic dev_ack = dev_match && !busy; // [RULE9]
  wire logic ack_grant = (state_r == TWS_DEV) ? dev_ack :
                         (state_r == TWS_MADDR) ? 1'b1 :
                         (state_r == TWS_WDATA) ? !wp_in : 1'b0; // [RULE10]
  wire logic read_load = ack_end && (((state_r == TWS_DEV) && rw_r) || ((state_r == TWS_READ) && mack_r));
  wire logic drive_bit = scl_fall && (state_r == TWS_READ) && (cnt_r != 4'h0) && (cnt_r < `TWS_BIT_ACK);

  // =====================================================================
  // State and bit counter; a start from any state restarts the bus [RULE6]
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= TWS_IDLE;
      cnt_r <= 4'h0;
    end
    else if (start)
    begin
      state_r <= TWS_DEV; // [RULE2]
      cnt_r <= 4'h0;
    end
    else if (stop)
    begin
      state_r <= TWS_IDLE; // [RULE3]
      cnt_r <= 4'h0;
    end
    else if (byte_done && (state_r == TWS_DEV) && !dev_ack)
      state_r <= TWS_IDLE; // [RULE9]
    else if (ack_end)
    begin
      cnt_r <= 4'h0;
      unique case (state_r)
        TWS_DEV: state_r <= rw_r ? TWS_READ : TWS_MADDR; // [RULE8]
        TWS_MADDR: state_r <= TWS_WDATA;
        TWS_WDATA: state_r <= TWS_WDATA; // [RULE12]
        TWS_READ: state_r <= mack_r ? TWS_READ : TWS_IDLE; // [RULE19]
        TWS_IDLE: state_r <= TWS_IDLE;
      endcase
    end
    else if (scl_rise && (state_r != TWS_IDLE))
      cnt_r <= cnt_r + 4'h1;
  end

  // =====================================================================
  // Shift register: samples on clock rise, unloads read data MSB first
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      shift_r <= 8'h00;
    else if (ce_in)
    begin
      if (scl_rise && receiving && (cnt_r < `TWS_BIT_ACK))
        shift_r <= {shift_r[6:0], sda_in}; // [RULE1]
      else if (read_load)
        shift_r <= {rd_data[6:0], 1'b1}; // [RULE16]
      else if (drive_bit)
        shift_r <= {shift_r[6:0], 1'b1};
    end
  end

  // Direction bit taken at the eighth clock fall; master acknowledge sampled on the ninth rise
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (byte_done && (state_r == TWS_DEV))
        rw_r <= shift_r[0]; // [RULE8]
      if (scl_rise && (state_r == TWS_READ) && (cnt_r == `TWS_BIT_ACK))
        mack_r <= ~sda_in; // [RULE18]
    end
  end

  // =====================================================================
  // Data line pull-down; changes only right after a clock fall
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      sda_low_r <= 1'b0;
    else if (start || stop)
      sda_low_r <= 1'b0;
    else if (byte_done)
      sda_low_r <= receiving && ack_grant; // [RULE4]
    else if (read_load)
      sda_low_r <= ~rd_data[7]; // [RULE16]
    else if (ack_end)
      sda_low_r <= 1'b0;
    else if (drive_bit)
      sda_low_r <= ~shift_r[7]; // [RULE1]
  end

  // =====================================================================
  // Address pointer and page write address
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ptr_r <= 8'h00;
      waddr_r <= 8'h00;
    end
    else if (ce_in)
    begin
      if (byte_done && (state_r == TWS_MADDR))
      begin
        ptr_r <= shift_r; // [RULE17]
        waddr_r <= shift_r;
      end
      else if (buf_wr)
      begin
        waddr_r <= tws_page_next(waddr_r); // [RULE22]
        ptr_r <= tws_page_next(waddr_r); // [RULE15]
      end
      else if (read_load)
        ptr_r <= ptr_r + 8'h01; // [RULE18]
    end
  end

  // Pending write flag: set by an accepted data byte, cleared by start or stop
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      wr_pend_r <= 1'b0;
    else if (start || stop)
      wr_pend_r <= 1'b0; // [RULE13]
    else if (buf_wr)
      wr_pend_r <= 1'b1;
  end

  // =====================================================================
  // Open-drain output and status levels
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_low_r;
  assign standby_out = (state_r == TWS_IDLE) && !busy; // [RULE5]
  assign conv_hold_out = (state_r != TWS_IDLE) || busy; // [RULE21]
  assign nv_busy_out = busy;

  // =====================================================================
  // Assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  AST_PULL_ON_LOW_CLOCK: assert property ($rose(sda_low_r) |-> !scl_in) // [RULE1]
    else $error("Data pulled low while clock high");
  AST_START_TO_DEV: assert property (start |=> state_r == TWS_DEV && cnt_r == 4'h0 && !sda_oe_out) // [RULE2]
    else $error("Start did not restart the address phase");
  AST_STOP_TO_IDLE: assert property (stop |=> state_r == TWS_IDLE && !sda_oe_out) // [RULE3]
    else $error("Stop did not return to idle");
  AST_DEV_ACK: assert property (byte_done && state_r == TWS_DEV && dev_ack |=> sda_oe_out[*1] ##0 rw_r == $past(shift_r[0])) // [RULE4]
    else $error("Matching address not acknowledged");
  AST_DEV_MISMATCH: assert property (byte_done && state_r == TWS_DEV && !dev_match |=> !sda_oe_out && state_r == TWS_IDLE) // [RULE9]
    else $error("Mismatched address acknowledged");
  AST_MADDR_LOAD: assert property (byte_done && state_r == TWS_MADDR |=> sda_oe_out && ptr_r == $past(shift_r)) // [RULE10]
    else $error("Memory address not taken");
  AST_POLL_NACK: assert property (busy && byte_done && state_r == TWS_DEV |=> !sda_oe_out) // [RULE14]
    else $error("Address acknowledged during commit");
  AST_COMMIT_BUSY: assert property (stop && wr_pend_r |=> nv_busy_out && !standby_out) // [RULE11]
    else $error("Commit did not start after write stop");
  AST_WP_REJECT: assert property (byte_done && state_r == TWS_WDATA && wp_in |=> !sda_oe_out && waddr_r == $past(waddr_r)) // [RULE20]
    else $error("Protected write accepted");
  AST_READ_NEXT: assert property (ack_end && state_r == TWS_READ && mack_r |=> ptr_r == $past(ptr_r) + 8'h01) // [RULE18]
    else $error("Pointer did not advance on master ack");
  AST_PAGE_WRAP: assert property (buf_wr |=> waddr_r[7:3] == $past(waddr_r[7:3])) // [RULE22]
    else $error("Page write left its page");
  AST_HOLD_CONV: assert property (state_r != TWS_IDLE |-> conv_hold_out ##1 (state_r == TWS_IDLE || conv_hold_out)) // [RULE21]
    else $error("Conversion not held during transfer");

  // Release and read-side checks; the master must see a free line around its own acknowledge
  AST_ACK_RELEASE: assert property (ack_end && !read_load |=> !sda_oe_out) // [RULE4]
    else $error("Acknowledge held past the ninth clock");
  AST_READ_FIRST_BIT: assert property (read_load |=> sda_oe_out == !$past(rd_data[7])) // [RULE16]
    else $error("First read bit not driven from memory");
  AST_READ_RELEASE: assert property (byte_done && state_r == TWS_READ |=> !sda_oe_out) // [RULE18]
    else $error("Line not released for master acknowledge");
  AST_NACK_IDLE: assert property (ack_end && state_r == TWS_READ && !mack_r |=> state_r == TWS_IDLE && !sda_oe_out) // [RULE19]
    else $error("Read continued after master withheld acknowledge");

  // Commit-side checks; a cut write must never reach the array
  AST_BUSY_NO_STORE: assert property (busy |-> !buf_wr) // [RULE11]
    else $error("Data buffered during commit");
  AST_DISCARD: assert property (start && wr_pend_r |=> !nv_busy_out && !wr_pend_r) // [RULE13]
    else $error("Cut write was committed");
  AST_STANDBY_AFTER_STOP: assert property (stop && !wr_pend_r && !busy |=> standby_out) // [RULE5]
    else $error("No standby after stop");

  COV_READ_NACK: cover property (ack_end && state_r == TWS_READ && !mack_r);
  COV_PAGE_COMMIT: cover property (stop && wr_pend_r && waddr_r[2:0] == 3'h0);
  COV_POLL: cover property (busy && byte_done && state_r == TWS_DEV && dev_match);
  COV_SEQ_READ: cover property (read_load && state_r == TWS_READ);
  COV_WP_REJECT: cover property (byte_done && state_r == TWS_WDATA && wp_in);

endmodule : tws_slave

// file: sim/tws_master.sv
`timescale 1ns/1ps

// =====================================================================
// Bus master model: owns the serial clock and its side of the data line
module tws_master
(
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // Quarter bit in clocks; keeps both clock phases well above two clocks
  localparam int PH = 4;

  // Bus idles high on both lines
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic hold();
    repeat (PH) @(posedge clk_in);
  endtask : hold

  // Start or repeated start, data raised only while clock is low
  task automatic start();
    sda_out <= 1'b1;
    hold();
    scl_out <= 1'b1;
    hold();
    sda_out <= 1'b0;
    hold();
    scl_out <= 1'b0;
    hold();
  endtask : start

  // Stop: data rises while clock is high
  task automatic stop();
    sda_out <= 1'b0;
    hold();
    scl_out <= 1'b1;
    hold();
    sda_out <= 1'b1;
    hold();
  endtask : stop

  // One clock pulse; data set in the low phase, line sampled mid high phase
  task automatic bit_cycle(input logic b, output logic s);
    sda_out <= b;
    hold();
    scl_out <= 1'b1;
    hold();
    s = sda_in;
    hold();
    scl_out <= 1'b0;
    hold();
  endtask : bit_cycle

  // Byte out MSB first, line released for the ninth pulse
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(d[i], s);
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask : wbyte

  // Byte in; the last one is left without acknowledge
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b1, d[i]);
    bit_cycle(~more, s);
  endtask : rbyte
endmodule : tws_master

// file: sim/testbench.sv
`timescale 1ns/1ps

// =====================================================================
// Self-checking bench for the two-wire memory slave
module testbench;
  // Long enough that a poll lands inside the commit
  localparam logic [23:0] NV = 24'h000190;
  localparam logic [7:0] WA = 8'haa;
  logic clk_in;
  logic ce;
  logic rst_in;
  logic scl;
  logic m_sda;
  logic sda_w;
  logic s_sda;
  logic s_oe;
  logic wp;
  logic standby;
  logic conv_hold;
  logic busy;
  logic ack;
  logic [7:0] d;
  int n_mismatch;
  int samples_checked;
  int cycles;

  // Pull-up wire: low when either party pulls it
  assign sda_w = m_sda & (s_oe ? s_sda : 1'b1);

  tws_slave #(.NV_CYCLES(NV)) i_tws_slave (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .scl_in(scl),
    .sda_in(sda_w), .sda_out(s_sda), .sda_oe_out(s_oe), .select_pin_high_in(1'b1), .select_pin_mid_in(1'b0),
    .select_pin_low_in(1'b1), .wp_in(wp), .standby_out(standby), .conv_hold_out(conv_hold), .nv_busy_out(busy));

  tws_master i_tws_master (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));

  // =====================================================================
  // Clock, reset and hang guard
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Byte out with the acknowledge that should come back
  task automatic put(input logic [7:0] b, input logic exp);
    i_tws_master.wbyte(b, ack);
    check("ack", {7'h0, exp}, {7'h0, ack});
  endtask : put

  // Bounded wait for the commit to end, standby follows
  task automatic wait_idle();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++)
      @(posedge clk_in);
    @(posedge clk_in);
    check("standby", 8'h01, {7'h0, standby});
  endtask : wait_idle

  // Dummy write of the address, repeated start, sequential read
  task automatic rd_seq(input logic [7:0] a, input logic [7:0] e [3], input int n);
    i_tws_master.start();
    put(WA, 1'b1);
    put(a, 1'b1);
    i_tws_master.start();
    put(WA | 8'h01, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      i_tws_master.rbyte(i < n - 1, d);
      check("read", e[i], d);
    end
    i_tws_master.stop();
    @(posedge clk_in);
    check("standby", 8'h01, {7'h0, standby});
  endtask : rd_seq

  // =====================================================================
  // Scenarios
  task automatic s_reset();
    check("idle", 8'h08, {4'h0, standby, s_oe, busy, conv_hold});
  endtask : s_reset

  // With the enable low the slave sees nothing, so a valid address gets no ack
  task automatic s_freeze();
    ce <= 1'b0;
    i_tws_master.start();
    put(WA, 1'b0);
    i_tws_master.stop();
    ce <= 1'b1;
    check("frozen", 8'h08, {4'h0, standby, s_oe, busy, conv_hold});
  endtask : s_freeze

  task automatic s_refuse();
    i_tws_master.start();
    put(8'ha8, 1'b0);
    i_tws_master.start();
    put(8'hba, 1'b0);
    i_tws_master.stop();
    check("standby", 8'h01, {7'h0, standby});
  endtask : s_refuse

  task automatic s_write_poll();
    i_tws_master.start();
    put(WA, 1'b1);
    check("conv_hold", 8'h01, {7'h0, conv_hold});
    put(8'h00, 1'b1);
    put(8'h5a, 1'b1);
    put(8'ha5, 1'b1);
    i_tws_master.stop();
    @(posedge clk_in);
    @(posedge clk_in);
    check("busy", 8'h10, {3'h0, busy, 3'h0, standby});
    i_tws_master.start();
    put(WA | 8'h01, 1'b0);
    i_tws_master.stop();
    wait_idle();
    i_tws_master.start();
    put(WA, 1'b1);
    i_tws_master.stop();
  endtask : s_write_poll

  // Nine bytes into the top page: the ninth lands on the page start
  task automatic s_page();
    i_tws_master.start();
    put(WA, 1'b1);
    put(8'hf8, 1'b1);
    for (int i = 0; i < 9; i++)
      put(8'h80 + 8'(i), 1'b1);
    i_tws_master.stop();
    wait_idle();
    i_tws_master.start();
    put(WA | 8'h01, 1'b1);
    i_tws_master.rbyte(1'b0, d);
    check("current", 8'h81, d);
    i_tws_master.stop();
    rd_seq(8'hff, '{8'h87, 8'h5a, 8'ha5}, 3);
    rd_seq(8'hf8, '{8'h88, 8'h00, 8'h00}, 1);
  endtask : s_page

  // Write cut short by a repeated start never reaches the array
  task automatic s_abort();
    i_tws_master.start();
    put(WA, 1'b1);
    put(8'h00, 1'b1);
    put(8'h11, 1'b1);
    rd_seq(8'h00, '{8'h5a, 8'h00, 8'h00}, 1);
    check("busy", 8'h00, {7'h0, busy});
  endtask : s_abort

  task automatic s_protect();
    wp <= 1'b1;
    i_tws_master.start();
    put(WA, 1'b1);
    put(8'h00, 1'b1);
    put(8'h33, 1'b0);
    i_tws_master.stop();
    @(posedge clk_in);
    check("busy", 8'h00, {7'h0, busy});
    wp <= 1'b0;
    rd_seq(8'h00, '{8'h5a, 8'h00, 8'h00}, 1);
  endtask : s_protect

  // =====================================================================
  // Main sequence
  initial
  begin
    rst_in = 1'b1;
    ce = 1'b1;
    wp = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    s_reset();
    s_freeze();
    s_refuse();
    s_write_poll();
    s_page();
    s_abort();
    s_protect();
    wrap_up();
  end
endmodule : testbench
